//--- design/accel_sample_duty_cycler.sv
// Function
// - Wake, sample, send, maybe ack, sleep
// - Loop repeats every 50 ms
// - X channel 1, Y 2, Z 0
// - Enable analog pins 0 to 2 only
// - Conversions at 8-bit resolution
// - High speed, bus clock, prescale 8
// - X then Y then Z each pass
// - Two to exponent samples per channel
// - Exponent resets to zero
// - Shift back, invert X and Y
// - Send raw uncalibrated values
// - Transmit only after data acquired
// - Receive window every eighth loop only
// - Acknowledge tracks link status
// - Load sleep time and enter stop in the same cycle
module accel_sample_duty_cycler
#(
   parameter int unsigned LOOP_CYCLES = asdc_pkg::LOOP_PERIOD_CYCLES,
   parameter int unsigned ACK_CYCLES = asdc_pkg::ACK_WINDOW_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Configuration
   input wire logic [asdc_pkg::EXP_W-1:0] oversample_exponent,
   input wire logic oversample_load,
   // Converter
   output logic [7:0] analog_pin_enable_mask,
   output logic [7:0] converter_config,
   output asdc_pkg::asdc_conv_cmd_type conversion_channel_select,
   input wire logic conversion_complete_flag,
   input wire logic [7:0] conversion_result,
   // Frame sender
   output logic frame_valid,
   output asdc_pkg::asdc_frame_type frame,
   input wire logic frame_done,
   output logic rx_enable,
   input wire logic ack_received,
   output logic link_ok,
   // Transceiver doze timer
   output logic [31:0] doze_compare,
   output logic doze_load,
   output logic stop_mode,
   input wire logic wake_irq
);
   import asdc_pkg::*;

   asdc_state_type state;
   asdc_state_type next_state;
   logic [EXP_W-1:0] exponent;
   logic [EXP_W-1:0] next_exponent;
   logic [7:0] pass;
   logic [7:0] next_pass;
   logic [1:0] axis;
   logic [1:0] next_axis;
   logic [2:0] loop_cnt;
   logic [2:0] next_loop_cnt;
   logic [31:0] elapsed;
   logic [31:0] next_elapsed;
   logic [31:0] rx_timer;
   logic [31:0] next_rx_timer;
   asdc_conv_cmd_type next_cmd;
   logic next_frame_valid;
   asdc_frame_type next_frame;
   logic next_rx_enable;
   logic next_link_ok;
   logic [31:0] next_doze_compare;
   logic next_doze_load;
   logic next_stop_mode;

   // Pin synchronisers
   logic conversion_complete_flag_meta;
   logic conversion_complete_flag_sync;
   logic conversion_complete_flag_prev;
   logic [7:0] result_meta;
   logic [7:0] result_sync;
   logic wake_meta;
   logic wake_sync;
   logic conversion_complete_flag_rise;

   // Accumulator control
   logic acc_clear;
   logic acc_add;
   logic acc_latch;
   asdc_frame_type acc_result;
   logic [7:0] last_pass;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         conversion_complete_flag_meta <= 1'b0;
         conversion_complete_flag_sync <= 1'b0;
         conversion_complete_flag_prev <= 1'b0;
         result_meta <= 8'h00;
         result_sync <= 8'h00;
         wake_meta <= 1'b0;
         wake_sync <= 1'b0;
      end
      else
      begin
         conversion_complete_flag_meta <= conversion_complete_flag;
         conversion_complete_flag_sync <= conversion_complete_flag_meta;
         conversion_complete_flag_prev <= conversion_complete_flag_sync;
         result_meta <= conversion_result;
         result_sync <= result_meta;
         wake_meta <= wake_irq;
         wake_sync <= wake_meta;
      end
   end

   // Edge, not level: a stale flag from the last conversion must not count
   assign conversion_complete_flag_rise = conversion_complete_flag_sync & ~conversion_complete_flag_prev;

   assign last_pass = (8'h01 << exponent) - 8'h01;

   assign acc_clear = (state == ST_START);
   assign acc_add = (state == ST_WAIT) && conversion_complete_flag_rise;
   assign acc_latch = (state == ST_SCALE);

   asdc_accum u_accum
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .clear(acc_clear),
      .add_en(acc_add),
      .axis(axis),
      .sample(result_sync),
      .exponent(exponent),
      .latch(acc_latch),
      .result(acc_result)
   );

   always_comb
   begin
      next_state = state;
      next_exponent = exponent;
      next_pass = pass;
      next_axis = axis;
      next_loop_cnt = loop_cnt;
      next_elapsed = (elapsed == 32'hffff_ffff) ? elapsed : elapsed + 32'h0000_0001;
      next_rx_timer = rx_timer;
      next_cmd.channel = conversion_channel_select.channel;
      next_cmd.start = 1'b0;
      next_frame_valid = 1'b0;
      next_frame = frame;
      next_rx_enable = rx_enable;
      next_link_ok = link_ok;
      next_doze_compare = doze_compare;
      next_doze_load = 1'b0;
      next_stop_mode = stop_mode;
      // Taken only between loops so one loop never mixes two exponents
      if (oversample_load && (state == ST_SLEEP || state == ST_START))
      begin
         next_exponent = oversample_exponent;
      end
      unique case (state)
         ST_START:
         begin
            next_pass = 8'h00;
            next_axis = AXIS_X;
            next_state = ST_CONV;
         end
         ST_CONV:
         begin
            next_cmd.start = 1'b1;
            unique case (axis)
               AXIS_X: next_cmd.channel = CHANNEL_X;
               AXIS_Y: next_cmd.channel = CHANNEL_Y;
               default: next_cmd.channel = CHANNEL_Z;
            endcase
            next_state = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (conversion_complete_flag_rise)
            begin
               if (axis == AXIS_Z)
               begin
                  next_axis = AXIS_X;
                  if (pass == last_pass)
                  begin
                     next_state = ST_SCALE;
                  end
                  else
                  begin
                     next_pass = pass + 8'h01;
                     next_state = ST_CONV;
                  end
               end
               else
               begin
                  next_axis = axis + 2'h1;
                  next_state = ST_CONV;
               end
            end
         end
         ST_SCALE:
         begin
            next_state = ST_SEND;
         end
         ST_SEND:
         begin
            next_frame = acc_result;
            next_frame_valid = 1'b1;
            next_state = ST_TXWAIT;
         end
         ST_TXWAIT:
         begin
            if (frame_done)
            begin
               next_loop_cnt = loop_cnt + 3'h1;
               if (loop_cnt == RX_LOOP_SLOT)
               begin
                  next_rx_enable = 1'b1;
                  next_rx_timer = 32'h0000_0000;
                  next_state = ST_RX;
               end
               else
               begin
                  next_state = ST_DOZE;
               end
            end
         end
         ST_RX:
         begin
            next_rx_timer = rx_timer + 32'h0000_0001;
            if (ack_received)
            begin
               next_link_ok = 1'b1;
               next_rx_enable = 1'b0;
               next_state = ST_DOZE;
            end
            else if (rx_timer == 32'(ACK_CYCLES) - 32'h0000_0001)
            begin
               next_link_ok = 1'b0;
               next_rx_enable = 1'b0;
               next_state = ST_DOZE;
            end
         end
         ST_DOZE:
         begin
            if (elapsed + MIN_SLEEP_CYCLES < 32'(LOOP_CYCLES))
            begin
               next_doze_compare = 32'(LOOP_CYCLES) - elapsed;
            end
            else
            begin
               next_doze_compare = MIN_SLEEP_CYCLES;
            end
            next_doze_load = 1'b1;
            next_stop_mode = 1'b1;
            next_state = ST_SLEEP;
         end
         ST_SLEEP:
         begin
            if (wake_sync)
            begin
               next_stop_mode = 1'b0;
               next_elapsed = 32'h0000_0000;
               next_state = ST_START;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state <= ST_START;
         exponent <= OVERSAMPLE_EXP_RESET;
         pass <= 8'h00;
         axis <= AXIS_X;
         loop_cnt <= 3'h0;
         elapsed <= 32'h0000_0000;
         rx_timer <= 32'h0000_0000;
         conversion_channel_select <= '0;
         frame_valid <= 1'b0;
         frame <= '0;
         rx_enable <= 1'b0;
         link_ok <= 1'b0;
         doze_compare <= 32'h0000_0000;
         doze_load <= 1'b0;
         stop_mode <= 1'b0;
      end
      else
      begin
         state <= next_state;
         exponent <= next_exponent;
         pass <= next_pass;
         axis <= next_axis;
         loop_cnt <= next_loop_cnt;
         elapsed <= next_elapsed;
         rx_timer <= next_rx_timer;
         conversion_channel_select <= next_cmd;
         frame_valid <= next_frame_valid;
         frame <= next_frame;
         rx_enable <= next_rx_enable;
         link_ok <= next_link_ok;
         doze_compare <= next_doze_compare;
         doze_load <= next_doze_load;
         stop_mode <= next_stop_mode;
      end
   end

   // Fixed converter setup, loaded on the first clock after reset
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         analog_pin_enable_mask <= 8'h00;
         converter_config <= 8'h00;
      end
      else
      begin
         analog_pin_enable_mask <= PIN_ENABLE_MASK;
         converter_config <= CONVERTER_CONFIG;
      end
   end

endmodule

//--- design/asdc_pkg.sv
package asdc_pkg;

   // Clock and loop timing
   localparam int unsigned CLK_FREQ_KHZ = 100000;
   localparam int unsigned LOOP_PERIOD_MS = 50;
   localparam int unsigned LOOP_PERIOD_CYCLES = LOOP_PERIOD_MS * CLK_FREQ_KHZ;
   localparam int unsigned ACK_WINDOW_US = 2000;
   localparam int unsigned ACK_WINDOW_CYCLES = (ACK_WINDOW_US * CLK_FREQ_KHZ) / 1000;
   localparam logic [31:0] MIN_SLEEP_CYCLES = 32'h0000_0001;

   // Converter setup values
   localparam logic [7:0] PIN_ENABLE_MASK = 8'h07;
   localparam logic [7:0] CONVERTER_CONFIG = 8'h60;
   localparam logic [1:0] CLOCK_SOURCE_BUS = 2'h0;
   localparam int unsigned CLOCK_SOURCE_POS = 0;
   localparam int unsigned PRESCALE_POS = 5;
   localparam int unsigned RESULT_BITS = 8;

   // Channel per axis
   localparam logic [4:0] CHANNEL_X = 5'h01;
   localparam logic [4:0] CHANNEL_Y = 5'h02;
   localparam logic [4:0] CHANNEL_Z = 5'h00;
   localparam logic [1:0] AXIS_X = 2'h0;
   localparam logic [1:0] AXIS_Y = 2'h1;
   localparam logic [1:0] AXIS_Z = 2'h2;
   localparam int unsigned AXIS_COUNT = 3;

   // Oversampling and inversion
   localparam int unsigned EXP_W = 3;
   localparam logic [2:0] OVERSAMPLE_EXP_RESET = 3'h0;
   localparam int unsigned SUM_W = 15;
   localparam logic [2:0] INVERT_MASK = 3'h3;

   // Acknowledge every eighth loop
   localparam logic [2:0] RX_LOOP_SLOT = 3'h0;

   typedef struct packed {
      logic [7:0] x;
      logic [7:0] y;
      logic [7:0] z;
   } asdc_frame_type;

   typedef struct packed {
      logic [4:0] channel;
      logic start;
   } asdc_conv_cmd_type;

   typedef enum logic [8:0] {
      ST_START = 9'h001,
      ST_CONV = 9'h002,
      ST_WAIT = 9'h004,
      ST_SCALE = 9'h008,
      ST_SEND = 9'h010,
      ST_TXWAIT = 9'h020,
      ST_RX = 9'h040,
      ST_DOZE = 9'h080,
      ST_SLEEP = 9'h100
   } asdc_state_type;

endpackage

//--- design/asdc_accum.sv
module asdc_accum
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Control
   input wire logic clear,
   input wire logic add_en,
   input wire logic [1:0] axis,
   input wire logic [7:0] sample,
   input wire logic [asdc_pkg::EXP_W-1:0] exponent,
   input wire logic latch,
   // Result
   output asdc_pkg::asdc_frame_type result
);
   import asdc_pkg::*;

   logic [SUM_W-1:0] sum [AXIS_COUNT];
   logic [SUM_W-1:0] next_sum [AXIS_COUNT];
   logic [7:0] value [AXIS_COUNT];
   logic [7:0] next_value [AXIS_COUNT];

   genvar g;
   generate
      for (g = 0; g < AXIS_COUNT; g++)
      begin : gen_axis
         logic [SUM_W-1:0] shifted;
         always_comb
         begin
            shifted = sum[g] >> exponent;
            next_sum[g] = sum[g];
            next_value[g] = value[g];
            if (clear)
            begin
               next_sum[g] = '0;
            end
            else if (add_en && axis == 2'(g))
            begin
               next_sum[g] = sum[g] + {{(SUM_W-8){1'b0}}, sample};
            end
            if (latch)
            begin
               next_value[g] = INVERT_MASK[g] ? ~shifted[7:0] : shifted[7:0];
            end
         end
         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               sum[g] <= '0;
               value[g] <= 8'h00;
            end
            else
            begin
               sum[g] <= next_sum[g];
               value[g] <= next_value[g];
            end
         end
      end
   endgenerate

   assign result.x = value[0];
   assign result.y = value[1];
   assign result.z = value[2];

endmodule

//--- bench/asdc_props.sv
module asdc_props
   import asdc_pkg::*;
#(
   parameter int unsigned LOOP_CYCLES = 2000,
   parameter int unsigned ACK_CYCLES = 50
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Converter
   input wire logic [7:0] analog_pin_enable_mask,
   input wire logic [7:0] converter_config,
   input wire asdc_pkg::asdc_conv_cmd_type conversion_channel_select,
   // Sender and link
   input wire logic frame_valid,
   input wire logic rx_enable,
   input wire logic ack_received,
   input wire logic link_ok,
   // Doze timer
   input wire logic [31:0] doze_compare,
   input wire logic doze_load,
   input wire logic stop_mode,
   input wire logic wake_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   localparam int WIN_MAX = ACK_CYCLES + 2;
   logic [4:0] prev_ch;
   logic [4:0] exp_ch;
   logic [2:0] loop_cnt;
   always_comb
   begin
      exp_ch = (prev_ch == CHANNEL_X) ? CHANNEL_Y : (prev_ch == CHANNEL_Y) ? CHANNEL_Z : CHANNEL_X;
   end
   // Loop count mirrors the receive slot; a reset restarts both
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         prev_ch <= CHANNEL_Z;
         loop_cnt <= 3'h0;
      end
      else
      begin
         if (conversion_channel_select.start)
            prev_ch <= conversion_channel_select.channel;
         if (frame_valid)
            loop_cnt <= loop_cnt + 3'h1;
      end
   end
   sequence s_ack_taken;
      rx_enable && ack_received;
   endsequence
   sequence s_link_up;
      !rx_enable && link_ok;
   endsequence
   a_pin_mask: assert property (!$past(sys_rst) |-> analog_pin_enable_mask == 8'h07)
      else $error("analog pin mask wrong");
   a_conv_config: assert property (!$past(sys_rst) |-> converter_config == 8'h60)
      else $error("converter config wrong");
   a_axis_order: assert property (conversion_channel_select.start |->
      conversion_channel_select.channel == exp_ch)
      else $error("axis order wrong");
   a_tx_after_data: assert property (frame_valid |-> !stop_mode && prev_ch == CHANNEL_Z ##1 !frame_valid)
      else $error("frame sent before data complete");
   a_rx_slot: assert property ($rose(rx_enable) |-> loop_cnt == 3'h1)
      else $error("receive window outside slot");
   a_ack_link: assert property (s_ack_taken |=> s_link_up)
      else $error("acknowledge not taken");
   a_link_lost: assert property ($rose(rx_enable) |-> ##[1:WIN_MAX] !rx_enable)
      else $error("receive window too long");
   a_doze_load: assert property (doze_load |->
      stop_mode && doze_compare != 32'h0 && doze_compare <= LOOP_CYCLES)
      else $error("doze load wrong");
   a_wake_exit: assert property (stop_mode && $rose(wake_irq) |-> ##[1:4] !stop_mode)
      else $error("wake not taken");
endmodule

//--- bench/asdc_partner.sv
module asdc_partner
   import asdc_pkg::*;
(
   // Clock, reset, test control
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ack_en,
   // Converter
   input wire asdc_pkg::asdc_conv_cmd_type conversion_channel_select,
   output logic conversion_complete_flag,
   output logic [7:0] conversion_result,
   // Frame sender
   input wire logic frame_valid,
   output logic frame_done,
   input wire logic rx_enable,
   output logic ack_received,
   // Doze timer
   input wire logic [31:0] doze_compare,
   input wire logic doze_load,
   input wire logic stop_mode,
   output logic wake_irq
);
   logic [2:0] adc_cnt;
   logic [4:0] adc_ch;
   logic [2:0] tx_cnt;
   logic [3:0] ack_cnt;
   logic [31:0] doze_cnt;
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         {adc_cnt, adc_ch, tx_cnt, ack_cnt, doze_cnt} <= '0;
         {conversion_complete_flag, conversion_result, frame_done, ack_received, wake_irq} <= '0;
      end
      else
      begin
         if (conversion_channel_select.start)
         begin
            adc_cnt <= 3'h5;
            adc_ch <= conversion_channel_select.channel;
            conversion_complete_flag <= 1'b0;
         end
         else
         begin
            if (adc_cnt == 3'h1)
               conversion_result <= (adc_ch == CHANNEL_X) ? 8'h30 : (adc_ch == CHANNEL_Y) ? 8'h81 : 8'hc4;
            // Junk while no result, so a stale read shows
            else if (!conversion_complete_flag)
               conversion_result <= ~conversion_result;
            conversion_complete_flag <= conversion_complete_flag | (adc_cnt == 3'h1);
            if (adc_cnt != 3'h0)
               adc_cnt <= adc_cnt - 3'h1;
         end
         tx_cnt <= frame_valid ? 3'h4 : (tx_cnt != 3'h0) ? tx_cnt - 3'h1 : tx_cnt;
         frame_done <= tx_cnt == 3'h1;
         ack_cnt <= !rx_enable ? 4'h0 : (ack_cnt != 4'hf) ? ack_cnt + 4'h1 : ack_cnt;
         ack_received <= ack_en && rx_enable && ack_cnt == 4'h6;
         doze_cnt <= doze_load ? doze_compare : (doze_cnt != 32'h0) ? doze_cnt - 32'h1 : doze_cnt;
         if (doze_cnt == 32'h1 && stop_mode)
            wake_irq <= 1'b1;
         else if (!stop_mode)
            wake_irq <= 1'b0;
      end
   end
endmodule

//--- bench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import asdc_pkg::*;
   localparam int unsigned LOOP_N = 2000;
   logic clk = 1'b0;
   logic sys_rst = 1'b0;
   logic [2:0] oversample_exponent = 3'h0;
   logic oversample_load = 1'b0;
   logic ack_en = 1'b1;
   logic [7:0] analog_pin_enable_mask, converter_config, conversion_result;
   asdc_conv_cmd_type conversion_channel_select;
   asdc_frame_type frame;
   logic [31:0] doze_compare;
   logic conversion_complete_flag, frame_valid, frame_done, rx_enable, ack_received;
   logic link_ok, doze_load, stop_mode, wake_irq, rx_prev;
   int fail_count = 0;
   int cmp_count = 0;
   int starts = 0;
   int loops = 0;
   int rx_opens = 0;
   time t_prev;
   typedef struct {logic [2:0] e; int n;} asdc_row_type;
   asdc_row_type rows[4] = '{'{3'h1, 6}, '{3'h7, 384}, '{3'h3, 24}, '{3'h0, 3}};
   always #5 clk = ~clk;
   accel_sample_duty_cycler #(.LOOP_CYCLES(LOOP_N), .ACK_CYCLES(50)) u_dut (.clk(clk), .sys_rst(sys_rst),
      .oversample_exponent(oversample_exponent), .oversample_load(oversample_load),
      .analog_pin_enable_mask(analog_pin_enable_mask), .converter_config(converter_config),
      .conversion_channel_select(conversion_channel_select), .conversion_complete_flag(conversion_complete_flag),
      .conversion_result(conversion_result), .frame_valid(frame_valid), .frame(frame), .frame_done(frame_done),
      .rx_enable(rx_enable), .ack_received(ack_received), .link_ok(link_ok), .doze_compare(doze_compare),
      .doze_load(doze_load), .stop_mode(stop_mode), .wake_irq(wake_irq));
   asdc_partner u_partner (.clk(clk), .sys_rst(sys_rst), .ack_en(ack_en),
      .conversion_channel_select(conversion_channel_select), .conversion_complete_flag(conversion_complete_flag),
      .conversion_result(conversion_result), .frame_valid(frame_valid), .frame_done(frame_done),
      .rx_enable(rx_enable), .ack_received(ack_received), .doze_compare(doze_compare),
      .doze_load(doze_load), .stop_mode(stop_mode), .wake_irq(wake_irq));
   always @(posedge clk)
   begin
      starts += (conversion_channel_select.start === 1'b1);
      loops += (frame_valid === 1'b1);
      rx_opens += (rx_enable === 1'b1 && rx_prev !== 1'b1);
      rx_prev = rx_enable;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
      cmp_count++;
      if (seen !== want)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s seen %h want %h", $time, what, seen, want);
      end
   endtask
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // 0 frame, 1 asleep, 2 window open, 3 window shut
   task automatic wait_on(input int k);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (n < 4 * LOOP_N && !(k == 0 ? frame_valid === 1'b1 : k == 1 ? stop_mode === 1'b1 :
         k == 2 ? rx_enable === 1'b1 : rx_enable === 1'b0));
      if (n >= 4 * LOOP_N)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: wait %0d timed out", $time, k);
         conclude();
      end
   endtask
   task automatic do_reset();
      sys_rst = 1'b1;
      repeat (20) @(posedge clk);
      #1;
      check({analog_pin_enable_mask, converter_config, 7'h0, stop_mode, 7'h0, link_ok}, 32'h0, "reset");
      sys_rst = 1'b0;
      {starts, loops, rx_opens} = '0;
   endtask
   task automatic load_exp(input logic [2:0] e);
      oversample_exponent = e;
      oversample_load = 1'b1;
      @(posedge clk);
      #1;
      oversample_load = 1'b0;
      starts = 0;
   endtask
   initial
   begin
      do_reset();
      wait_on(0);
      check(starts, 3, "default samples");
      check(32'(analog_pin_enable_mask), 32'h07, "pin mask");
      check(32'(converter_config), 32'h60, "config");
      wait_on(2);
      wait_on(3);
      check(32'(link_ok), 32'h1, "link after ack");
      foreach (rows[i])
      begin
         wait_on(1);
         load_exp(rows[i].e);
         wait_on(0);
         check(starts, rows[i].n, "samples per loop");
         check(32'(frame), 32'hcf7ec4, "frame");
      end
      ack_en = 1'b0;
      // Frame count lags a returned wait by one edge, so 8 means frame 9 is out
      while (loops < 8)
         wait_on(0);
      wait_on(2);
      wait_on(3);
      check(32'(link_ok), 32'h0, "link lost");
      wait_on(0);
      t_prev = $time;
      wait_on(0);
      check(32'(($time - t_prev) / 10 >= LOOP_N && ($time - t_prev) / 10 <= LOOP_N + 16), 32'h1, "period");
      check(rx_opens, 2, "windows");
      // Reset while asleep must drop a loaded exponent
      wait_on(1);
      load_exp(3'h7);
      do_reset();
      wait_on(0);
      check(starts, 3, "exponent after reset");
      conclude();
   end
endmodule
bind accel_sample_duty_cycler asdc_props #(.LOOP_CYCLES(LOOP_CYCLES), .ACK_CYCLES(ACK_CYCLES)) u_props (
   .clk(clk), .sys_rst(sys_rst), .analog_pin_enable_mask(analog_pin_enable_mask),
   .converter_config(converter_config), .conversion_channel_select(conversion_channel_select),
   .frame_valid(frame_valid), .rx_enable(rx_enable), .ack_received(ack_received), .link_ok(link_ok),
   .doze_compare(doze_compare), .doze_load(doze_load), .stop_mode(stop_mode), .wake_irq(wake_irq));
